// ===== verilog/gpio_io_logic_cell.sv
// Top: per-pin I/O logic between core fabric and pad buffer
`timescale 1ns/1ps
// What this block does
// - Input mode: only receive path, optionally registered
// - Capture register uses selectable capture clock edge
// - Bypass route from pad skips capture registers, resampled on ref_clk_i
// - Dual-edge input: two capture registers, two streams, not on differential pins
// - Output mode: only transmit path, selectable edge
// - Registered output may be inverted
// - Dual-edge output: two launch registers muxed, not on differential pins
// - Bidirectional: all paths, proper clocks
// - Bidirectional: per-register edge, independent registering
// - Clock-output mode forwards core clock to pad
// - Bypass route feeds other blocks directly
// - Configuration: ordinary pins weak pull-up
// - Differential pins: tri-state, no pull, configuring
// - Unused pins: tri-state, pull-up or pull-down, no pull-down on differential pins
// - No glitch entering user mode with pull-up
// - Rise sample first bit, fall sample second
// - Resync delays fall sample half clock
module gpio_io_logic_cell
(
   input wire logic ref_clk_i, // Housekeeping clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic capture_clock_i, // Input register clock
   input wire logic launch_clock_i, // Output and OE register clock
   input wire logic tree_clock_i, // Core clock tree signal for clock-out
   input wire gpio_cell_pkg::pin_mode_type mode_i, // Pin mode
   input wire logic [1:0] rx_reg_i, // Receive register option
   input wire logic [1:0] tx_reg_i, // Transmit register option
   input wire logic oe_reg_i, // Register the output enable
   input wire logic rx_neg_i, // Capture on falling edge
   input wire logic tx_neg_i, // Launch on falling edge
   input wire logic oe_neg_i, // OE register on falling edge
   input wire logic tx_invert_i, // Invert registered output
   input wire logic diff_pin_i, // Differential pin used single-ended
   input wire logic unused_pull_down_i, // Unused pin pulls down instead of up; differential pins then get no pull
   input wire logic configuring_i, // Device configuration in progress
   input wire logic tx_bit_rise_i, // Core data, rising-edge bit
   input wire logic tx_bit_fall_i, // Core data, falling-edge bit
   input wire logic oe_i, // Core output enable
   input wire logic pad_i, // Pad level seen by input buffer
   output logic pad_o, // Pad drive value
   output logic pad_oe_o, // Pad driven while high
   output logic pull_up_o, // Weak pull-up enable
   output logic pull_down_o, // Weak pull-down enable
   output logic rx_bit_rise_o, // Received data, rising sample
   output logic rx_bit_fall_o, // Received data, falling sample
   output logic bypass_route_o, // Alternate input, skips capture registers, resampled on ref_clk_i
   output logic cfg_done_o // Synchronised end-of-configuration level
);
   import gpio_cell_pkg::*;
   // ==========================================================
   // Reset release and configuration status synchroniser
   logic rst_s1_r; // Reset release stage 1
   logic rst_n_r; // Released reset copy
   logic [2:0] cfg_sync_r; // Configuring flag synchroniser
   logic configuring_r; // Filtered configuring level
   // Reset release through two flops
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end
   // Three-stage sampling; change accepted when stages 2 and 3 agree
   always_ff @(posedge ref_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         cfg_sync_r <= 3'h7;
         configuring_r <= 1'b1;
      end
      else
      begin
         cfg_sync_r <= {cfg_sync_r[1:0], configuring_i};
         if (cfg_sync_r[1] == cfg_sync_r[2])
            configuring_r <= cfg_sync_r[2];
      end
   end
   // ==========================================================
   // Mode decode
   wire rx_en = (mode_i == MODE_INPUT) || (mode_i == MODE_BIDIR);
   wire tx_en = (mode_i == MODE_OUTPUT) || (mode_i == MODE_BIDIR);
   wire clk_en = (mode_i == MODE_CLKOUT);
   wire bypass_en = (mode_i == MODE_BYPASS_IN);
   wire rx_dual = rx_reg_i[1] && !diff_pin_i;
   wire tx_dual = tx_reg_i[1] && !diff_pin_i;
   // ==========================================================
   // Receive path: capture registers on capture clock
   logic cap_single; // Single register, selectable edge
   logic cap_rise_r; // Dual-edge rising sample
   logic cap_fall_r; // Dual-edge falling sample
   logic cap_fall_rs_r; // Falling sample moved to rising edge
   // Single capture register, edge chosen per register
   edge_sel_flop u_cap
   (
      .clk_i(capture_clock_i),
      .rst_n_i(rst_n_r),
      .neg_edge_i(rx_neg_i),
      .d_i(pad_i),
      .q_o(cap_single)
   );
   // Dual-edge rising sample
   always_ff @(posedge capture_clock_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         cap_rise_r <= RST_DATA;
         cap_fall_rs_r <= RST_DATA;
      end
      else
      begin
         cap_rise_r <= pad_i;
         cap_fall_rs_r <= cap_fall_r;
      end
   end
   // Dual-edge falling sample
   always_ff @(negedge capture_clock_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
         cap_fall_r <= RST_DATA;
      else
         cap_fall_r <= pad_i;
   end
   // Receive selection; REG_NONE, or dual-edge on a differential pin, falls back to the pad level
   wire rx_rise_sel = !rx_en ? 1'b0 :
                      rx_dual ? cap_rise_r :
                      (rx_reg_i == REG_SINGLE) ? cap_single : pad_i;
   wire rx_fall_sel = !(rx_en && rx_dual) ? 1'b0 :
                      (rx_reg_i == REG_DUAL_RESYNC) ? cap_fall_rs_r :
                      cap_fall_r;
   // ==========================================================
   // Transmit path: launch registers on launch clock
   logic tx_single; // Single launch register
   logic tx_rise_r; // Dual-edge rising bit
   logic tx_fall_r; // Dual-edge falling bit
   logic tx_fall_hold_r; // Falling bit taken at rise, core order
   logic oe_q; // Registered output enable
   edge_sel_flop u_launch
   (
      .clk_i(launch_clock_i),
      .rst_n_i(rst_n_r),
      .neg_edge_i(tx_neg_i),
      .d_i(tx_bit_rise_i),
      .q_o(tx_single)
   );
   // OE register has its own edge choice
   edge_sel_flop u_oe
   (
      .clk_i(launch_clock_i),
      .rst_n_i(rst_n_r),
      .neg_edge_i(oe_neg_i),
      .d_i(oe_i),
      .q_o(oe_q)
   );
   // Both core bits are taken on the rising edge
   always_ff @(posedge launch_clock_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         tx_rise_r <= RST_DATA;
         tx_fall_hold_r <= RST_DATA;
      end
      else
      begin
         tx_rise_r <= tx_bit_rise_i;
         tx_fall_hold_r <= tx_bit_fall_i;
      end
   end
   // Falling bit launched on the falling edge
   always_ff @(negedge launch_clock_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
         tx_fall_r <= RST_DATA;
      else
         tx_fall_r <= tx_fall_hold_r;
   end
   // Dual-edge mux: high phase shows rise bit, low phase the fall bit
   wire tx_dual_val = launch_clock_i ? tx_rise_r : tx_fall_r;
   wire tx_reg_val = tx_dual ? tx_dual_val : tx_single;
   wire tx_val = (tx_reg_i == REG_NONE) ? tx_bit_rise_i :
                 (tx_reg_val ^ tx_invert_i);
   wire oe_val = oe_reg_i ? oe_q : oe_i;
   // ==========================================================
   // Pad drive and pull control
   wire user_mode = !configuring_r;
   wire drive_en = user_mode && (clk_en || (tx_en &&
                   ((mode_i == MODE_OUTPUT) || oe_val)));
   wire drive_val = clk_en ? tree_clock_i : tx_val;
   wire pad_unused = (mode_i == MODE_UNUSED);
   // Pull-up during configuration except differential pins
   // and on unused pins not set to pull down; pull-up stays on across the edge only on unused non-differential pins not set to pull down
   wire pu_nxt = configuring_r ? !diff_pin_i :
                 (pad_unused && !unused_pull_down_i);
   wire pd_nxt = user_mode && pad_unused && unused_pull_down_i && !diff_pin_i;
   // Registered pad and status outputs
   always_ff @(posedge ref_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         pad_oe_o <= RST_OE;
         pull_up_o <= 1'b1;
         pull_down_o <= 1'b0;
         cfg_done_o <= 1'b0;
      end
      else
      begin
         pad_oe_o <= drive_en;
         pull_up_o <= pu_nxt;
         pull_down_o <= pd_nxt;
         cfg_done_o <= user_mode;
      end
   end
   // Data outputs are all resampled on the rising edge of ref_clk_i
   always_ff @(posedge ref_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         pad_o <= RST_DATA;
         rx_bit_rise_o <= RST_DATA;
         rx_bit_fall_o <= RST_DATA;
         bypass_route_o <= RST_DATA;
      end
      else
      begin
         pad_o <= drive_val;
         rx_bit_rise_o <= rx_rise_sel;
         rx_bit_fall_o <= rx_fall_sel;
         bypass_route_o <= bypass_en ? pad_i : 1'b0;
      end
   end
   // ==========================================================
   // Checks
   AST_CFG_PULLUP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (configuring_r && !diff_pin_i) |=> pull_up_o)
      else $error("pull-up missing during configuration");
   AST_DIFF_FLOAT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (configuring_r && diff_pin_i) |=> (!pull_up_o && !pull_down_o && !pad_oe_o))
      else $error("differential pin not floating during configuration");
   AST_UNUSED_PULL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (!configuring_r && pad_unused && !diff_pin_i)
      |=> (!pad_oe_o && (pull_down_o == $past(unused_pull_down_i))
           && (pull_up_o != pull_down_o)))
      else $error("unused pin pull state wrong");
   AST_NO_GLITCH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      ($fell(configuring_r) && pad_unused && !unused_pull_down_i && !diff_pin_i)
      |-> ##1 pull_up_o [*2])
      else $error("pull-up glitch at user mode entry");
   AST_OE_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (mode_i == MODE_BIDIR && !oe_val) |=> !pad_oe_o)
      else $error("pad driven with enable low");
   AST_INPUT_NODRIVE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (mode_i == MODE_INPUT) |=> !pad_oe_o)
      else $error("input mode drives pad");
   AST_COMB_RX: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (rx_en && rx_reg_i == REG_NONE) |=> (rx_bit_rise_o == $past(pad_i)))
      else $error("combinational receive mismatch");
   AST_BYPASS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      bypass_en |=> (bypass_route_o == $past(pad_i)))
      else $error("bypass route not direct");
   AST_OUT_DRIVE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (mode_i == MODE_OUTPUT && !configuring_r) |=> pad_oe_o)
      else $error("output mode not driving");
   AST_CLKOUT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_r)
      (clk_en && !configuring_r) |=> (pad_oe_o && pad_o == $past(tree_clock_i)))
      else $error("clock output not forwarded");
endmodule : gpio_io_logic_cell

// ===== verilog/gpio_cell_pkg.sv
// Package: configuration encodings and reset values for the I/O logic cell
package gpio_cell_pkg;
   // ==========================================================
   // Pin mode encodings
   typedef enum logic [2:0]
   {
      MODE_UNUSED = 3'h0,
      MODE_INPUT = 3'h1,
      MODE_OUTPUT = 3'h2,
      MODE_BIDIR = 3'h3,
      MODE_CLKOUT = 3'h4,
      MODE_BYPASS_IN = 3'h5
   } pin_mode_type;
   // ==========================================================
   // Register option encodings per path
   localparam logic [1:0] REG_NONE = 2'h0; // Combinational route
   localparam logic [1:0] REG_SINGLE = 2'h1; // One register
   localparam logic [1:0] REG_DUAL = 2'h2; // Dual-edge normal
   localparam logic [1:0] REG_DUAL_RESYNC = 2'h3; // Dual-edge, resynchronised to rise
   // ==========================================================
   // Pad pull encodings
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_UP = 2'h1;
   localparam logic [1:0] PULL_DOWN = 2'h2;
   // Reset values of data registers
   localparam logic RST_DATA = 1'b0;
   localparam logic RST_OE = 1'b0;
endpackage : gpio_cell_pkg

// ===== verilog/edge_sel_flop.sv
// Single flip-flop whose active clock edge is chosen by configuration
`timescale 1ns/1ps
module edge_sel_flop
(
   input wire logic clk_i, // Register clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic neg_edge_i, // High selects the falling edge
   input wire logic d_i, // Data in
   output logic q_o // Data out
);
   import gpio_cell_pkg::*;
   // ==========================================================
   // Rising and falling copies, then select
   logic rise_r; // Sampled on rising edge
   logic fall_r; // Sampled on falling edge
   // Rising-edge capture
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rise_r <= RST_DATA;
      else
         rise_r <= d_i;
   end
   // Falling-edge capture
   always_ff @(negedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         fall_r <= RST_DATA;
      else
         fall_r <= d_i;
   end
   assign q_o = neg_edge_i ? fall_r : rise_r;
endmodule : edge_sel_flop

// ===== testbench/pad_side_model.sv
// Pad side model: outside driver, weak pulls and a floating pad
`timescale 1ns/1ps
module pad_side_model
(
   input wire logic clk_i, // Bench clock
   input wire logic pad_i, // Cell drive value
   input wire logic pad_oe_i, // Cell drives the pad
   input wire logic pull_up_i, // Weak pull-up on
   input wire logic pull_down_i, // Weak pull-down on
   input wire logic ext_en_i, // Outside driver on
   input wire logic ext_val_i, // Outside driver value
   output logic level_o // Resolved pad level
);
   logic last_r = 1'b0; // Level seen last cycle
   // ==========================================================
   // Resolve the wire; an undriven pad with no pull wanders
   always_comb
   begin
      if (pad_oe_i)
         level_o = pad_i;
      else if (ext_en_i)
         level_o = ext_val_i;
      else if (pull_up_i || pull_down_i)
         level_o = pull_up_i;
      else
         level_o = ~last_r;
   end
   // Remember the level so that a float toggles each cycle
   always @(posedge clk_i)
      last_r <= level_o;
endmodule : pad_side_model

// ===== testbench/gpio_io_logic_cell_tb.sv
// Self-checking testbench for the per-pin I/O logic cell
`timescale 1ns/1ps
module gpio_io_logic_cell_tb;
   import gpio_cell_pkg::*;
   // ==========================================================
   // Stimulus, slow clock phase and observed outputs
   logic clk = 1'b0, rst_n = 1'b0, conf = 1'b1, diff = 1'b0, pdn = 1'b0;
   logic [3:0] ph = 4'h0; // Slow clocks: rise at 0, fall at 8
   pin_mode_type mode = MODE_UNUSED;
   logic [1:0] rxr = 2'h0;
   logic [1:0] txr = 2'h0; // Transmit register option, apart from receive
   logic tneg = 1'b0, dv; // Transmit edge choice and a drawn core bit
   logic neg = 1'b0, inv = 1'b0, txa = 1'b0, txb = 1'b0, oe = 1'b0;
   logic xen = 1'b0, xv = 1'b0, lvl; // Outside driver and pad level
   logic pad, pad_oe, pu, pd, rxa, rxb, byp, done;
   int err_count = 0;
   int comparisons = 0;
   int s, k;
   // ==========================================================
   // Clocks and the design
   initial
      forever #2.5 clk = ~clk;
   always @(posedge clk)
      ph <= ph + 4'h1;
   gpio_io_logic_cell dut
   (
      .ref_clk_i(clk), .rst_n_i(rst_n), .capture_clock_i(~ph[3]),
      .launch_clock_i(~ph[3]), .tree_clock_i(ph[2]), .mode_i(mode),
      .rx_reg_i(rxr), .tx_reg_i(txr), .oe_reg_i(rxr[0]), .rx_neg_i(neg),
      .tx_neg_i(tneg), .oe_neg_i(neg), .tx_invert_i(inv), .diff_pin_i(diff),
      .unused_pull_down_i(pdn), .configuring_i(conf), .tx_bit_rise_i(txa),
      .tx_bit_fall_i(txb), .oe_i(oe), .pad_i(lvl), .pad_o(pad), .pad_oe_o(pad_oe),
      .pull_up_o(pu), .pull_down_o(pd), .rx_bit_rise_o(rxa), .rx_bit_fall_o(rxb),
      .bypass_route_o(byp), .cfg_done_o(done)
   );
   pad_side_model far
   (
      .clk_i(clk), .pad_i(pad), .pad_oe_i(pad_oe), .pull_up_i(pu),
      .pull_down_i(pd), .ext_en_i(xen), .ext_val_i(xv), .level_o(lvl)
   );
   // ==========================================================
   // Shared tasks
   task automatic test_done();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   // Count a compare and report a difference
   task automatic chk(input string nm, input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %b seen %b", nm, exp, seen);
      end
   endtask : chk
   // Wait at a falling ref edge for a slow clock phase, bounded
   task automatic at(input logic [3:0] p);
      for (int n = 0; n < 40; n++)
      begin
         @(negedge clk);
         if (ph == p)
            return;
      end
      err_count++;
      test_done();
   endtask : at
   // Apply a pin setup; outside driver only where the pin listens
   task automatic cfg(input pin_mode_type m, input logic [1:0] r, input logic n);
      @(posedge clk);
      mode <= m;
      rxr <= r;
      txr <= r;
      neg <= n;
      tneg <= n;
      inv <= 1'($urandom);
      xen <= (m == MODE_INPUT || m == MODE_BYPASS_IN || m == MODE_BIDIR);
   endtask : cfg
   // Drive the source of a path: 0 transmit, 1/3 pad, 2 enable
   task automatic drv(input int sel, input logic v);
      @(posedge clk);
      case (sel)
         0: txa <= v;
         1, 3: xv <= v;
         default: oe <= v;
      endcase
   endtask : drv
   // Output of a path, with the chosen inversion removed
   function automatic logic obs(input int sel);
      case (sel)
         0: return pad ^ (inv && txr != REG_NONE);
         1: return rxa;
         2: return pad_oe;
         default: return byp;
      endcase
   endfunction : obs
   // Change a source between clock edges and watch when it lands
   task automatic edge_test(input int sel, input logic r, input logic n);
      logic old;
      logic comb;
      comb = !r || sel == 3;
      cfg(sel == 0 ? MODE_OUTPUT : sel == 1 ? MODE_INPUT :
          sel == 2 ? MODE_BIDIR : MODE_BYPASS_IN, {1'b0, r || sel == 3}, n);
      at(2);
      old = 1'($urandom);
      drv(sel, old);
      at(2);
      drv(sel, ~old);
      at(6);
      chk("early", obs(sel), comb ? ~old : old);
      at(14);
      chk("half", obs(sel), (comb || n) ? ~old : old);
      at(6);
      chk("full", obs(sel), ~old);
      if (sel == 1)
         chk("rx_oe", pad_oe, 1'b0);
   endtask : edge_test
   // Dual-edge capture, plain or moved to the rising edge
   task automatic ddr_in(input logic rs);
      logic a;
      logic b;
      logic pb;
      b = 1'b0;
      cfg(MODE_INPUT, rs ? REG_DUAL_RESYNC : REG_DUAL, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         at(12);
         if (i > 0)
            chk("ddr_fall", rxb, rs ? pb : b);
         pb = b;
         a = 1'($urandom);
         drv(1, a);
         at(4);
         chk("ddr_rise", rxa, a);
         if (i > 1)
            chk("ddr_prev", rxb, pb);
         b = ~pb;
         drv(1, b);
      end
   endtask : ddr_in
   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'hb13e));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(negedge clk);
      chk("cfg_pu", pu, 1'b1);
      chk("cfg_done", done, 1'b0);
      cfg(MODE_OUTPUT, REG_NONE, 1'b0);
      diff <= 1'b1;
      repeat (6) @(negedge clk);
      chk("diff_pu", pu | pd, 1'b0);
      chk("diff_oe", pad_oe, 1'b0);
      cfg(MODE_UNUSED, REG_NONE, 1'b0);
      diff <= 1'b0;
      repeat (4) @(posedge clk);
      conf <= 1'b0;
      repeat (10)
      begin
         @(negedge clk);
         chk("glitch_pu", pu, 1'b1);
      end
      chk("user_done", done, 1'b1);
      chk("unused_oe", pad_oe, 1'b0);
      @(posedge clk);
      pdn <= 1'b1;
      repeat (4) @(negedge clk);
      chk("unused_pd", pd & ~pu & ~pad_oe, 1'b1);
      for (s = 0; s < 4; s++)
         for (k = 0; k < 3; k++)
            edge_test(s, k > 0, k == 2);
      ddr_in(1'b0);
      ddr_in(1'b1);
      cfg(MODE_OUTPUT, REG_DUAL, 1'b0);
      for (k = 0; k < 4; k++)
      begin
         at(12);
         if (k > 0)
            chk("ddr_out_low", obs(0), txb);
         dv = 1'($urandom);
         drv(0, dv);
         txb <= ~dv;
         at(4);
         chk("ddr_out_high", obs(0), txa);
      end
      cfg(MODE_BIDIR, REG_NONE, 1'b0);
      drv(2, 1'b0);
      for (k = 0; k < 2; k++)
      begin
         drv(1, k[0]);
         repeat (4) @(negedge clk);
         chk("bidir_off_oe", pad_oe, 1'b0);
         chk("bidir_off_rx", rxa, k[0]);
      end
      // Receive stays combinational while transmit registers on the fall
      drv(2, 1'b1);
      @(posedge clk);
      txr <= REG_SINGLE;
      tneg <= 1'b1;
      at(2);
      dv = 1'($urandom);
      drv(0, dv);
      at(14);
      chk("bidir_tx", obs(0), dv);
      chk("bidir_rx", rxa, dv ^ inv);
      chk("bidir_oe", pad_oe, 1'b1);
      cfg(MODE_CLKOUT, REG_NONE, 1'b0);
      at(12);
      at(3);
      chk("clk_low", pad, 1'b0);
      at(7);
      chk("clk_high", pad & pad_oe, 1'b1);
      test_done();
   end
endmodule : gpio_io_logic_cell_tb
